// ==== core/rbc_pkg.sv ====
`default_nettype none
package rbc_pkg;
    // register location on the command port
    localparam logic [7:0] RBC_CTRL_ADDR = 8'h60;
    // field positions inside the control register
    localparam int RBC_POS_MODE_HI = 6;
    localparam int RBC_POS_MODE_LO = 5;
    localparam int RBC_POS_RTR = 3;
    localparam int RBC_POS_ROLL = 2;
    localparam int RBC_POS_MIRROR = 1;
    localparam int RBC_POS_HIT = 0;
    // reset values
    localparam logic RBC_RST_RTR = 1'h0;
    localparam logic RBC_RST_ROLL = 1'h0;
    localparam logic RBC_RST_HIT = 1'h0;
    localparam logic [7:0] RBC_RST_RDATA = 8'h00;

    // receive filter mode codes
    typedef enum logic [1:0] {
        RBC_MODE_FILTERED = 2'b00,
        RBC_MODE_RSV01 = 2'b01,
        RBC_MODE_RSV10 = 2'b10,
        RBC_MODE_ACCEPT_ANY = 2'b11
    } rbc_mode_e;

    // message events from the protocol engine and the filters
    typedef struct packed {
        logic done;
        logic err;
        logic rtr;
        logic hit0;
        logic hit1;
    } rbc_msg_s;

    // host register access after command decode
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rbc_host_s;

    // complete state of the control block
    typedef struct packed {
        rbc_mode_e mode;
        logic rtr;
        logic roll;
        logic hit;
        logic [7:0] rdata;
        logic load_high;
        logic load_low;
        logic ovf;
        logic load_hit;
    } rbc_state_s;
endpackage
`default_nettype wire

// ==== core/rbc_accept.sv ====
`timescale 1ns/100ps
`default_nettype none
module rbc_accept
(
    input wire rbc_pkg::rbc_mode_e mode_i,
    input wire rbc_pkg::rbc_msg_s msg_i,
    output logic accept_o,
    output logic hit_o
);
    import rbc_pkg::*;

    // acceptance decision for the high priority buffer
    always_comb
    begin
        if (mode_i == RBC_MODE_ACCEPT_ANY)
        begin
            accept_o = msg_i.done | msg_i.err;
        end
        else
        begin
            // reserved codes fall back to filtered reception
            accept_o = msg_i.done & (msg_i.hit0 | msg_i.hit1);
        end
        // filter zero wins when both match
        hit_o = ~msg_i.hit0 & msg_i.hit1;
    end
endmodule
`default_nettype wire

// ==== core/rbc_rx_buffer0_control.sv ====
// Overview of operation
// - Mode 11 bypasses masks and filters; every received message is accepted.
// - Mode 00 loads only valid messages meeting filter criteria, standard or extended.
// - On load into buffer zero, bit 3 records whether the message was a remote request.
// - On load into either buffer, bit 0 reports filter one as 1, filter zero as 0.
// - Rollover enabled: full buffer moves message to second buffer, overflow only if that one is full too.
// - No load while the buffer's full flag is set; host clears it.
// - Accept-any mode still loads a partial message that ended in error.
`timescale 1ns/100ps
`default_nettype none
module rbc_rx_buffer0_control
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire rbc_pkg::rbc_host_s HOST_I,
    input wire rbc_pkg::rbc_msg_s MSG_I,
    input wire logic HIGH_FULL_I,
    input wire logic LOW_FULL_I,
    output logic [7:0] CTRL_RDATA_O,
    output logic LOAD_HIGH_O,
    output logic LOAD_LOW_O,
    output logic OVERFLOW_O,
    output logic LOAD_HIT_O
);
    import rbc_pkg::*;

    rbc_state_s s_r;
    rbc_state_s s_nxt;
    logic accept;
    logic hit_idx;
    logic [7:0] ctrl_view;

    // acceptance decision from mode and filter results
    rbc_accept u_accept
    (
        .mode_i(s_r.mode),
        .msg_i(MSG_I),
        .accept_o(accept),
        .hit_o(hit_idx)
    );

    // register image as the host reads it
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[RBC_POS_MODE_HI:RBC_POS_MODE_LO] = s_r.mode;
        ctrl_view[RBC_POS_RTR] = s_r.rtr;
        ctrl_view[RBC_POS_ROLL] = s_r.roll;
        ctrl_view[RBC_POS_MIRROR] = s_r.roll;
        ctrl_view[RBC_POS_HIT] = s_r.hit;
    end

    // next state: host access and message routing
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.load_high = 1'b0;
        s_nxt.load_low = 1'b0;
        s_nxt.ovf = 1'b0;
        // host write: only mode and rollover are writable
        if (HOST_I.wr && HOST_I.addr == RBC_CTRL_ADDR)
        begin
            s_nxt.mode = rbc_mode_e'(HOST_I.wdata[RBC_POS_MODE_HI:RBC_POS_MODE_LO]);
            s_nxt.roll = HOST_I.wdata[RBC_POS_ROLL];
        end
        // host read, unmapped addresses read as zero
        if (HOST_I.rd)
        begin
            s_nxt.rdata = (HOST_I.addr == RBC_CTRL_ADDR) ? ctrl_view : 8'h00;
        end
        // route an accepted message
        if (accept)
        begin
            s_nxt.load_hit = hit_idx;
            if (!HIGH_FULL_I)
            begin
                s_nxt.load_high = 1'b1;
                s_nxt.rtr = MSG_I.rtr;
                s_nxt.hit = hit_idx;
            end
            else if (s_r.roll && !LOW_FULL_I)
            begin
                s_nxt.load_low = 1'b1;
                s_nxt.hit = hit_idx; // a rolled message still reports its filter
            end
            else
            begin
                s_nxt.ovf = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            s_r.mode <= RBC_MODE_FILTERED;
            s_r.rtr <= RBC_RST_RTR;
            s_r.roll <= RBC_RST_ROLL;
            s_r.hit <= RBC_RST_HIT;
            s_r.rdata <= RBC_RST_RDATA;
            s_r.load_high <= 1'b0;
            s_r.load_low <= 1'b0;
            s_r.ovf <= 1'b0;
            s_r.load_hit <= RBC_RST_HIT;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flip-flops
    assign CTRL_RDATA_O = s_r.rdata;
    assign LOAD_HIGH_O = s_r.load_high;
    assign LOAD_LOW_O = s_r.load_low;
    assign OVERFLOW_O = s_r.ovf;
    assign LOAD_HIT_O = s_r.load_hit;

    // accept-any mode loads errored partial messages
    a_any_partial: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (s_r.mode == RBC_MODE_ACCEPT_ANY && MSG_I.err && !HIGH_FULL_I)
        |=> LOAD_HIGH_O
    )
    else $error("accept-any message not loaded");

    // filtered mode drops messages no filter matched
    a_filter_reject: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (s_r.mode == RBC_MODE_FILTERED && !MSG_I.hit0 && !MSG_I.hit1)
        |=> !LOAD_HIGH_O && !LOAD_LOW_O && !OVERFLOW_O
    )
    else $error("unmatched message was routed");

    // remote flag matches the loaded message
    a_rtr_capture: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        LOAD_HIGH_O |-> (s_r.rtr == $past(MSG_I.rtr)) ##1 ($stable(s_r.rtr) || LOAD_HIGH_O)
    )
    else $error("remote flag wrong after load");

    // filter hit index matches the accepting filter
    a_hit_report: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        LOAD_HIGH_O |-> s_r.hit == ($past(MSG_I.hit1) && !$past(MSG_I.hit0))
    )
    else $error("filter hit index wrong");

    // full buffer with rollover moves the message on
    a_roll_move: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (accept && HIGH_FULL_I && s_r.roll && !LOW_FULL_I)
        |=> LOAD_LOW_O && !OVERFLOW_O && !LOAD_HIGH_O
    )
    else $error("rollover did not move message");

    // full buffer without rollover overflows
    a_roll_off_ovf: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (accept && HIGH_FULL_I && !s_r.roll) |=> OVERFLOW_O && !LOAD_LOW_O
    )
    else $error("missing overflow without rollover");

    // a full buffer is never loaded
    a_full_lock: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        HIGH_FULL_I |=> !LOAD_HIGH_O
    )
    else $error("load while buffer full");

    // mirror bit follows rollover enable on reads
    a_mirror_bit: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (HOST_I.rd && HOST_I.addr == RBC_CTRL_ADDR)
        |=> CTRL_RDATA_O[RBC_POS_MIRROR] == CTRL_RDATA_O[RBC_POS_ROLL]
            && CTRL_RDATA_O[RBC_POS_ROLL] == $past(s_r.roll)
    )
    else $error("mirror bit differs from rollover");

    // at most one routing pulse per message
    a_one_answer: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        $onehot0({LOAD_HIGH_O, LOAD_LOW_O, OVERFLOW_O})
    )
    else $error("more than one routing pulse");

    // host write lands in the mode field
    a_mode_write: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (HOST_I.wr && HOST_I.addr == RBC_CTRL_ADDR)
        |=> s_r.mode == $past(HOST_I.wdata[RBC_POS_MODE_HI:RBC_POS_MODE_LO])
    )
    else $error("mode field not written");

    // host writes leave the status bits alone
    a_status_ro: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (HOST_I.wr && !accept) |=> $stable(s_r.rtr) && $stable(s_r.hit)
    )
    else $error("host write changed a status bit");

    // accept-any mode ignores the filters for complete messages
    a_any_done: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (s_r.mode == RBC_MODE_ACCEPT_ANY && MSG_I.done && !HIGH_FULL_I)
        |=> LOAD_HIGH_O
    )
    else $error("accept-any message dropped");

    // filtered mode loads a matched complete message
    a_filter_load: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (s_r.mode == RBC_MODE_FILTERED && MSG_I.done
            && (MSG_I.hit0 || MSG_I.hit1) && !HIGH_FULL_I)
        |=> LOAD_HIGH_O
    )
    else $error("matched message not loaded");

    // outside accept-any a message cut by an error is dropped
    a_filter_err: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (s_r.mode != RBC_MODE_ACCEPT_ANY && MSG_I.err && !MSG_I.done)
        |=> !LOAD_HIGH_O && !LOAD_LOW_O && !OVERFLOW_O
    )
    else $error("errored message routed outside accept-any");

    // rollover into a full second buffer is an overflow
    a_roll_full: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        (accept && HIGH_FULL_I && LOW_FULL_I) |=> OVERFLOW_O && !LOAD_LOW_O
    )
    else $error("load into a full second buffer");

    // a rolled message reports its filter in bit zero
    a_roll_hit: assert property (
        @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
        LOAD_LOW_O |-> s_r.hit == ($past(MSG_I.hit1) && !$past(MSG_I.hit0))
    )
    else $error("filter index wrong after rollover");
endmodule
`default_nettype wire

// ==== tb/rbc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// host side of the command port
module rbc_host_model
(
    input wire logic clk_i,
    output var rbc_pkg::rbc_host_s host_o
);
    import rbc_pkg::*;
    initial host_o = '0;
    // one access, held over one rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        if (wr && ^d[6:5])
            d[6:5] = 2'b00;
        @(negedge clk_i);
        host_o = '{wr, !wr, a, d};
        @(negedge clk_i);
        host_o = '0;
    endtask
endmodule
`default_nettype wire

// ==== tb/rbc_rx_buffer0_control_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// random traffic against the buffer zero control block
module rbc_rx_buffer0_control_tb;
    import rbc_pkg::*;
    logic clk = 0, rst_n = 0, hfull = 0, lfull = 0, roll = 0, rtr = 0, hit = 0;
    logic ld_hi, ld_lo, ovf, ld_hit;
    logic [7:0] rdata;
    logic [1:0] mode = 2'b00;
    rbc_host_s host;
    rbc_msg_s msg = '0;
    int error_cnt = 0, checks = 0, cyc = 0;

    rbc_host_model i_rbc_host_model (.clk_i(clk), .host_o(host));
    rbc_rx_buffer0_control i_rbc_rx_buffer0_control
    (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .HOST_I(host), .MSG_I(msg), .HIGH_FULL_I(hfull),
        .LOW_FULL_I(lfull), .CTRL_RDATA_O(rdata), .LOAD_HIGH_O(ld_hi), .LOAD_LOW_O(ld_lo),
        .OVERFLOW_O(ovf), .LOAD_HIT_O(ld_hit)
    );

    // clock and cycle ceiling
    initial
    begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask

    // expected register image
    function automatic logic [7:0] image();
        return {1'b0, mode, 1'b0, rtr, roll, roll, hit};
    endfunction

    // expected {high, low, overflow} pulses
    function automatic logic [2:0] route(rbc_msg_s m);
        logic acc;
        acc = (m.done | (m.err & mode == 2'b11)) & (mode == 2'b11 | m.hit0 | m.hit1);
        if (!acc)
            return 3'h0;
        if (!hfull)
            return 3'h4;
        return (roll & !lfull) ? 3'h2 : 3'h1;
    endfunction

    task automatic send(input rbc_msg_s m);
        logic [2:0] exp;
        exp = route(m);
        @(negedge clk);
        msg = m;
        @(negedge clk);
        msg = '0;
        check({ld_hi, ld_lo, ovf}, exp);
        if (exp[2] | exp[1])
            check({7'h00, ld_hit}, {7'h00, m.hit1 & !m.hit0});
        if (exp[2] | exp[1])
            hit = m.hit1 & !m.hit0;
        if (exp[2])
        begin
            rtr = m.rtr;
            hfull = 1'b1;
        end
    endtask

    task automatic wreg(input logic [7:0] d);
        i_rbc_host_model.access(1'b1, RBC_CTRL_ADDR, d);
        mode = {2{&d[6:5]}};
        roll = d[2];
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        i_rbc_host_model.access(1'b0, a, 8'h00);
        check(rdata, exp);
    endtask

    // reset, map corners, then random traffic
    initial
    begin
        rbc_msg_s m;
        m = rbc_msg_s'(5'($urandom(8101)));
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rreg(RBC_CTRL_ADDR, 8'h00);
        i_rbc_host_model.access(1'b1, 8'h61, 8'hFF);
        rreg(8'h61, 8'h00);
        rreg(RBC_CTRL_ADDR, 8'h00);
        send('{1'b1, 1'b0, 1'b1, 1'b0, 1'b1});
        rreg(RBC_CTRL_ADDR, image());
        $display("test reset and map done");
        for (int i = 0; i < 200; i++)
        begin
            if (i % 4 == 0)
                wreg(8'($urandom));
            m = rbc_msg_s'(5'($urandom));
            m.err = m.err & !m.done;
            if ($urandom % 3 == 0)
                hfull = 1'b0;
            lfull = 1'($urandom);
            send(m);
            rreg(RBC_CTRL_ADDR, image());
        end
        $display("test random traffic done");
        stop_test();
    end
endmodule
`default_nettype wire
